// *** src/video_digitizer_bus_control.sv ***
// register bank and acquisition-side control of the video digitizer card
// Function
// - 16-register window in 256 addresses; straps set base; 8-bit data
// - wait states: control 0, status 1, decoder 1/0, generator 0, table 2
// - control register powers up as all ones, leaving everything idle
// - control bits 1:0 pick camera channel and matching laser output, except in mode 00
// - control bit 2 forces all laser outputs to strap-selected idle level
// - control bit 3 releases drivers of all acquisition signals
// - bit 4 zero: counter steps per line; one: per table access
// - control bit 5 holds table address counter at zero
// - mode 00: channel follows table bits 7:6 each line
// - mode 01: channel buffered, taken at frame strobe falling edge
// - mode 10: as 01, table bit 6 drives vertical interrupt line
// - mode 11: control bits 1:0 select channel immediately
// - status bits 1:0 return the active channel
// - 2 kbyte table; bits 3:0 switch lasers, only selected one modulates
// - table bit 4 enables vertical window, bit 5 vertical clamping
// - modes 01 and 11 ignore table bits 7:6
// - 12-bit sample on top bits, bits 3:1 zero, bit 0 range flag
// - pixel words step by sixteen except out-of-range codes
// - strobes, region flag, data and field change on pixel clock rise
// - pixel clock stops at line end, resumes at next horizontal sync
// - line start strobe low one pixel clock per horizontal sync
// - frame strobe low one full line, changes at line strobe fall
// - field parity line: zero first field, changes before frame strobe
// - frame strobe clears table counter in normal acquisition
`timescale 1ns/1ps
module video_digitizer_bus_control
  import vdig_pkg::*;
#(
  parameter int LUT_WORDS = 2048
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register bus
  input wire vdig_pkg::bus_req_t i_bus,
  output logic o_bus_ack,
  output logic [7:0] o_bus_rdata,
  // straps
  input wire logic [3:0] i_base_strap,
  input wire logic i_laser_idle_strap,
  // sync decoder and sync generator register ports
  output logic o_sdec_wr,
  output logic o_sdec_rd,
  output logic o_sgen_wr,
  output logic [2:0] o_ext_index,
  output logic [7:0] o_ext_wdata,
  input wire logic [7:0] i_sdec_rdata,
  // camera side
  output logic [1:0] o_chan_sel,
  output logic [3:0] o_laser,
  output logic o_vert_clamp,
  output logic o_vertical_line_interrupt,
  // link domain inputs from the sync decoder and converter
  input wire logic i_link_clk,
  input wire logic i_hsync_det,
  input wire logic i_vsync_det,
  input wire logic i_line_end,
  input wire logic i_second_field,
  input wire logic i_hroi,
  input wire logic [11:0] i_adc_sample,
  input wire logic i_adc_ovf,
  // acquisition outputs to the bus
  output logic o_pclk,
  output logic o_line_start_strobe_n,
  output logic o_frame_start_strobe_n,
  output logic o_region_flag_n,
  output logic o_field_parity_line,
  output vdig_pkg::pixel_word_t o_pix_data,
  output logic o_acq_oe
);
  import vdig_pkg::*;

  // ********************************************************************
  // bus domain state
  // ********************************************************************
  typedef struct packed {
    bus_state_t st;
    logic [1:0] wcnt;
    logic wr;
    logic [3:0] ofs;
    logic [7:0] wdata;
    logic [7:0] ctrl;
    logic [LUT_AW-1:0] cnt;
    logic [1:0] buf_ch;
    logic [1:0] act_ch;
    logic [3:0] laser;
    logic clamp;
    logic irq;
    logic [7:0] rdata;
    logic [3:0] base_s1;
    logic [3:0] base_s2;
    logic idle_s1;
    logic idle_s2;
    logic [2:0] line_s;
    logic [2:0] frame_s;
  } bus_state_s_t;

  bus_state_s_t s_ff, nxt_s;
  logic [7:0] lut_mem [LUT_WORDS];
  logic [7:0] lut_q_ff;
  logic lut_we;
  logic hit;
  logic fire;
  logic line_ev;
  logic frame_ev;
  logic [1:0] ws;

  // wait states by offset and direction
  function automatic logic [1:0] wait_states(input logic [3:0] ofs,
                                             input logic wr);
    logic [1:0] w;
    w = WS_ZERO;
    if (ofs == OFS_STATUS) begin
      w = WS_ONE;
    end else if ((ofs == OFS_SDEC_INDEX || ofs == OFS_SDEC_DATA) && !wr) begin
      w = WS_ONE;
    end else if (ofs == OFS_LUT_DATA) begin
      w = WS_LUT;
    end
    return w;
  endfunction

  function automatic logic is_sdec(input logic [3:0] ofs);
    return ofs == OFS_SDEC_INDEX || ofs == OFS_SDEC_DATA;
  endfunction

  assign hit = i_bus.req && (i_bus.addr[7:4] == s_ff.base_s2);
  assign ws = wait_states(i_bus.addr[3:0], i_bus.wr);
  assign fire = (s_ff.st == BS_IDLE && hit && ws == WS_ZERO) ||
                (s_ff.st == BS_WAIT && s_ff.wcnt == WS_ONE);
  // edges seen on the third stage so the first stage feeds only the second
  assign line_ev = s_ff.line_s[2] ^ s_ff.line_s[1];
  assign frame_ev = s_ff.frame_s[2] ^ s_ff.frame_s[1];
  assign lut_we = fire && s_ff.st == BS_IDLE ? 1'b0 :
                  fire && s_ff.wr && s_ff.ofs == OFS_LUT_DATA;

  logic line_tg_ff, frame_tg_ff;

  always_comb begin
    logic [3:0] ofs;
    logic wr;
    logic [7:0] wd;
    ofs = s_ff.st == BS_IDLE ? i_bus.addr[3:0] : s_ff.ofs;
    wr = s_ff.st == BS_IDLE ? i_bus.wr : s_ff.wr;
    wd = s_ff.st == BS_IDLE ? i_bus.wdata : s_ff.wdata;
    nxt_s = s_ff;
    nxt_s.base_s1 = i_base_strap;
    nxt_s.base_s2 = s_ff.base_s1;
    nxt_s.idle_s1 = i_laser_idle_strap;
    nxt_s.idle_s2 = s_ff.idle_s1;
    nxt_s.line_s = {s_ff.line_s[1:0], line_tg_ff};
    nxt_s.frame_s = {s_ff.frame_s[1:0], frame_tg_ff};
    // access sequencer
    case (s_ff.st)
      BS_IDLE: begin
        if (hit) begin
          nxt_s.ofs = i_bus.addr[3:0];
          nxt_s.wr = i_bus.wr;
          nxt_s.wdata = i_bus.wdata;
          nxt_s.wcnt = ws;
          nxt_s.st = ws == WS_ZERO ? BS_ACK : BS_WAIT;
        end
      end
      BS_WAIT: begin
        nxt_s.wcnt = s_ff.wcnt - WS_ONE;
        if (s_ff.wcnt == WS_ONE) begin
          nxt_s.st = BS_ACK;
        end
      end
      BS_ACK: begin
        nxt_s.st = i_bus.req ? BS_HOLD : BS_IDLE;
      end
      BS_HOLD: begin
        if (!i_bus.req) begin
          nxt_s.st = BS_IDLE;
        end
      end
      default: nxt_s.st = BS_IDLE;
    endcase
    // register effects at the cycle the answer is produced
    if (fire) begin
      nxt_s.rdata = 8'h00;
      if (wr && ofs == OFS_CTRL) begin
        nxt_s.ctrl = wd;
      end else if (!wr && ofs == OFS_STATUS) begin
        nxt_s.rdata = {6'h00, s_ff.act_ch};
      end else if (!wr && is_sdec(ofs)) begin
        nxt_s.rdata = i_sdec_rdata;
      end else if (!wr && ofs == OFS_LUT_DATA) begin
        nxt_s.rdata = lut_q_ff;
      end
    end
    // table address counter
    if (s_ff.ctrl[CTRL_CNT_CLR]) begin
      nxt_s.cnt = CNT_ZERO;
    end else if (!s_ff.ctrl[CTRL_LUT_PROG] && frame_ev) begin
      nxt_s.cnt = CNT_ZERO;
    end else if (!s_ff.ctrl[CTRL_LUT_PROG] && line_ev) begin
      nxt_s.cnt = s_ff.cnt + CNT_ONE;
    end else if (s_ff.ctrl[CTRL_LUT_PROG] && fire &&
                 ofs == OFS_LUT_DATA) begin
      nxt_s.cnt = s_ff.cnt + CNT_ONE;
    end
    // channel selection; unused table bits simply go unread
    if (frame_ev) begin
      nxt_s.buf_ch = s_ff.ctrl[1:0];
    end
    case (sel_mode_t'(s_ff.ctrl[7:6]))
      SEL_LUT: nxt_s.act_ch = lut_q_ff[7:6];
      SEL_BUF: nxt_s.act_ch = s_ff.buf_ch;
      SEL_BUF_IRQ: nxt_s.act_ch = s_ff.buf_ch;
      SEL_DIRECT: nxt_s.act_ch = s_ff.ctrl[1:0];
      default: nxt_s.act_ch = s_ff.ctrl[1:0];
    endcase
    nxt_s.irq = s_ff.ctrl[7:6] == SEL_BUF_IRQ && lut_q_ff[LUT_IRQ];
    nxt_s.clamp = lut_q_ff[LUT_CLAMP];
    for (int i = 0; i < 4; i++) begin
      // only the selected laser modulates; the rest sit at the idle level
      nxt_s.laser[i] = (!s_ff.ctrl[CTRL_LASER_DIS] && s_ff.act_ch == i &&
                        lut_q_ff[i]) ? !s_ff.idle_s2 : s_ff.idle_s2;
    end
    if (i_sys_rst) begin
      nxt_s = '0;
      nxt_s.st = BS_IDLE;
      nxt_s.ctrl = CTRL_RST;
      nxt_s.buf_ch = CHAN_RST;
      nxt_s.act_ch = CHAN_RST;
    end
  end

  always_ff @(posedge i_clk) begin
    s_ff <= nxt_s;
  end

  // table memory; contents are undefined after power-up
  always_ff @(posedge i_clk) begin
    if (lut_we) begin
      lut_mem[s_ff.cnt] <= s_ff.wdata;
    end
    lut_q_ff <= lut_mem[s_ff.cnt];
  end

  assign o_bus_ack = s_ff.st == BS_ACK;
  assign o_bus_rdata = s_ff.rdata;
  assign o_sdec_wr = fire && s_ff.st == BS_IDLE && i_bus.wr &&
                     is_sdec(i_bus.addr[3:0]);
  assign o_sdec_rd = s_ff.st == BS_WAIT && !s_ff.wr && is_sdec(s_ff.ofs);
  assign o_sgen_wr = fire && s_ff.st == BS_IDLE && i_bus.wr &&
                     i_bus.addr[3:2] == 2'h1;
  assign o_ext_index = i_bus.addr[2:0];
  assign o_ext_wdata = i_bus.wdata;
  assign o_chan_sel = s_ff.act_ch;
  assign o_laser = s_ff.laser;
  assign o_vert_clamp = s_ff.clamp;
  assign o_vertical_line_interrupt = s_ff.irq;

  // ********************************************************************
  // link domain: runs on the decoder's pixel clock
  // ********************************************************************
  typedef struct packed {
    logic [1:0] rst_s;
    logic oe_s1;
    logic oe_s2;
    logic vertical_window_enable_s1;
    logic vertical_window_enable_s2;
    logic run;
    logic line_n;
    logic frame_n;
    logic vpend;
    logic field;
    logic roi_n;
    logic line_tg;
    logic frame_tg;
    pixel_word_t data;
  } link_state_t;

  link_state_t l_ff, nxt_l;
  logic link_rst;

  // reset reaches the link only while its clock runs
  assign link_rst = l_ff.rst_s[1];

  always_comb begin
    nxt_l = l_ff;
    nxt_l.rst_s = {l_ff.rst_s[0], i_sys_rst};
    nxt_l.oe_s1 = !s_ff.ctrl[CTRL_BUS_DIS];
    nxt_l.oe_s2 = l_ff.oe_s1;
    nxt_l.vertical_window_enable_s1 = lut_q_ff[LUT_VERTICAL_WINDOW_ENABLE];
    nxt_l.vertical_window_enable_s2 = l_ff.vertical_window_enable_s1;
    nxt_l.line_n = !i_hsync_det;
    if (i_hsync_det) begin
      nxt_l.run = 1'b1;
      nxt_l.line_tg = !l_ff.line_tg;
      nxt_l.frame_n = !l_ff.vpend;
      nxt_l.vpend = 1'b0;
      if (l_ff.vpend) begin
        nxt_l.frame_tg = !l_ff.frame_tg;
      end
    end else if (i_line_end) begin
      nxt_l.run = 1'b0;
    end
    if (i_vsync_det) begin
      nxt_l.vpend = 1'b1;
      nxt_l.field = i_second_field;
    end
    nxt_l.roi_n = !(i_hroi && l_ff.vertical_window_enable_s2);
    nxt_l.data.sample = i_adc_sample;
    nxt_l.data.zero = 3'h0;
    nxt_l.data.ovf = i_adc_ovf;
    if (link_rst) begin
      nxt_l = '0;
      // keep shifting so the link side leaves reset once i_sys_rst drops
      nxt_l.rst_s = {l_ff.rst_s[0], i_sys_rst};
      nxt_l.line_n = 1'b1;
      nxt_l.frame_n = 1'b1;
      nxt_l.roi_n = 1'b1;
    end
  end

  always_ff @(posedge i_link_clk) begin
    l_ff <= nxt_l;
  end

  assign line_tg_ff = l_ff.line_tg;
  assign frame_tg_ff = l_ff.frame_tg;
  // gate opened after the rising edge, so a start cuts one high phase short
  assign o_pclk = i_link_clk & l_ff.run;
  assign o_line_start_strobe_n = l_ff.line_n;
  assign o_frame_start_strobe_n = l_ff.frame_n;
  assign o_region_flag_n = l_ff.roi_n;
  assign o_field_parity_line = l_ff.field;
  assign o_pix_data = l_ff.data;
  assign o_acq_oe = l_ff.oe_s2;

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence take_lut_s;
    s_ff.st == BS_IDLE && hit && i_bus.addr[3:0] == OFS_LUT_DATA;
  endsequence
  sequence lut_wait_s;
    !o_bus_ack [*2] ##1 o_bus_ack;
  endsequence

  AST_CTRL_RESET: assert property (disable iff (1'b0)
    $past(i_sys_rst) |-> s_ff.ctrl == CTRL_RST && s_ff.act_ch == CHAN_RST)
    else $error("control not all ones after reset");
  AST_WS_LUT: assert property (take_lut_s |=> lut_wait_s)
    else $error("table access wait states wrong");
  AST_WS_CTRL: assert property (
    s_ff.st == BS_IDLE && hit && i_bus.wr &&
    i_bus.addr[3:0] == OFS_CTRL |=> o_bus_ack)
    else $error("control write not answered next cycle");
  AST_CNT_HOLD: assert property (s_ff.ctrl[CTRL_CNT_CLR] |=>
    s_ff.cnt == CNT_ZERO)
    else $error("counter not held at zero");
  AST_CNT_WRAP: assert property (
    !s_ff.ctrl[CTRL_CNT_CLR] && s_ff.ctrl[CTRL_LUT_PROG] && fire &&
    s_ff.ofs == OFS_LUT_DATA && s_ff.st == BS_WAIT && &s_ff.cnt
    |=> s_ff.cnt == CNT_ZERO)
    else $error("counter did not wrap");
  AST_DIRECT: assert property (s_ff.ctrl[7:6] == SEL_DIRECT |=>
    s_ff.act_ch == $past(s_ff.ctrl[1:0]))
    else $error("direct mode channel mismatch");
  AST_LASER_OFF: assert property (s_ff.ctrl[CTRL_LASER_DIS] |=>
    o_laser == {4{$past(s_ff.idle_s2)}})
    else $error("lasers not idle while disabled");
  AST_STATUS: assert property (
    fire && s_ff.st == BS_WAIT && !s_ff.wr && s_ff.ofs == OFS_STATUS
    |=> o_bus_ack && o_bus_rdata == {6'h00, $past(s_ff.act_ch)})
    else $error("status read wrong");
  AST_IRQ_MODE: assert property (
    s_ff.ctrl[7:6] != SEL_BUF_IRQ |=> !o_vertical_line_interrupt)
    else $error("interrupt outside mode 10");
  AST_LINE_PULSE: assert property (@(posedge i_link_clk)
    disable iff (link_rst) !o_line_start_strobe_n && !i_hsync_det
    |=> o_line_start_strobe_n)
    else $error("line strobe longer than one pixel clock");
  AST_DATA_ZERO: assert property (@(posedge i_link_clk)
    disable iff (link_rst || i_sys_rst)
    $past(i_adc_sample) == o_pix_data.sample &&
    o_pix_data.zero == 3'h0)
    else $error("pixel word layout wrong");
endmodule

// *** src/vdig_pkg.sv ***
// shared constants and types of the video digitizer bus control block
package vdig_pkg;
  // ********************************************************************
  // register offsets within the 16-location window
  // ********************************************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_SDEC_INDEX = 4'h2;
  localparam logic [3:0] OFS_SDEC_DATA = 4'h3;
  localparam logic [3:0] OFS_SGEN_INDEX = 4'h4;
  localparam logic [3:0] OFS_SGEN_AUTOLOAD = 4'h5;
  localparam logic [3:0] OFS_SGEN_LOW = 4'h6;
  localparam logic [3:0] OFS_SGEN_HIGH = 4'h7;
  localparam logic [3:0] OFS_LUT_DATA = 4'h8;
  // ********************************************************************
  // wait states per access kind
  // ********************************************************************
  localparam logic [1:0] WS_ZERO = 2'h0;
  localparam logic [1:0] WS_ONE = 2'h1;
  localparam logic [1:0] WS_LUT = 2'h2;
  // ********************************************************************
  // control register and table fields, sizes and reset values
  // ********************************************************************
  localparam logic [7:0] CTRL_RST = 8'hFF;
  localparam int CTRL_LASER_DIS = 2;
  localparam int CTRL_BUS_DIS = 3;
  localparam int CTRL_LUT_PROG = 4;
  localparam int CTRL_CNT_CLR = 5;
  localparam int LUT_VERTICAL_WINDOW_ENABLE = 4;
  localparam int LUT_CLAMP = 5;
  localparam int LUT_IRQ = 6;
  localparam logic [1:0] CHAN_RST = 2'h3;
  localparam int LUT_AW = 11;
  localparam int LUT_DEPTH = 2048;
  localparam logic [LUT_AW-1:0] CNT_ZERO = 11'h000;
  localparam logic [LUT_AW-1:0] CNT_ONE = 11'h001;
  // ********************************************************************
  // types
  // ********************************************************************
  typedef enum logic [1:0] {
    SEL_LUT = 2'b00,
    SEL_BUF = 2'b01,
    SEL_BUF_IRQ = 2'b10,
    SEL_DIRECT = 2'b11
  } sel_mode_t;
  typedef enum logic [1:0] {
    BS_IDLE = 2'b00,
    BS_WAIT = 2'b01,
    BS_ACK = 2'b10,
    BS_HOLD = 2'b11
  } bus_state_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;
  typedef struct packed {
    logic [11:0] sample;
    logic [2:0] zero;
    logic ovf;
  } pixel_word_t;
endpackage

// *** testbench/bus_master_model.sv ***
// bus master model for the digitizer register window
`timescale 1ns/1ps
module bus_master_model
  import vdig_pkg::*;
(
  // clock
  input wire logic i_clk,
  // register bus
  output vdig_pkg::bus_req_t o_bus,
  input wire logic i_bus_ack,
  input wire logic [7:0] i_bus_rdata
);
  initial o_bus = '0;
  // ****************
  // byte cycle
  // ****************
  // held until ack is sampled; waits is -1 when no ack came at all
  task automatic access(input logic wr, input logic [7:0] addr,
    input logic [7:0] wdata, output logic [7:0] rdata, output int waits);
    waits = -1;
    rdata = 8'h00;
    o_bus = '{req: 1'b1, wr: wr, addr: addr, wdata: wdata};
    for (int n = 0; n < 12 && waits < 0; n++) begin
      @(posedge i_clk);
      if (i_bus_ack === 1'b1) begin
        waits = n - 1;
        rdata = i_bus_rdata;
      end
    end
    #1;
    // released lines show the inverse so stale values never look valid
    o_bus = '{req: 1'b0, wr: ~wr, addr: ~addr, wdata: ~wdata};
    @(posedge i_clk);
    #1;
  endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the digitizer bus control block
`timescale 1ns/1ps
module testbench;
  import vdig_pkg::*;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, lclk = 1'b0, idle = 1'b0;
  logic hs = 1'b0, vs = 1'b0, le = 1'b0, sf = 1'b0, hroi = 1'b1, ovf = 1'b0;
  logic [3:0] base = 4'h0;
  logic [7:0] sdec = 8'h00, wd;
  logic [11:0] smp = 12'h000;
  bus_req_t bus;
  logic ack, pclk, line_n, frame_n, roi_n, field, oe, clamp, irq, fe = 1'b0;
  logic [7:0] rdata;
  logic [1:0] chan, pend = 2'h0, che = 2'h3, bch = 2'h3;
  logic sdw, sdr, sgw;
  logic [3:0] laser;
  pixel_word_t pix;
  logic [7:0] tbl [2048];
  logic [8:0] exp_q [$];
  logic [8:0] note, e9;
  logic [10:0] idx = 11'h000;
  sel_mode_t mode = SEL_DIRECT;
  int fail_count = 0, num_checks = 0;
  int ext_wr = 0, ext_rd = 0;

  always #25 i_clk = ~i_clk;
  // link clock phase is offset so its edges never line up with i_clk
  initial begin
    #13;
    forever #40 lclk = ~lclk;
  end

  bus_master_model master_u (.i_clk(i_clk), .o_bus(bus), .i_bus_ack(ack),
    .i_bus_rdata(rdata));
  video_digitizer_bus_control #(.LUT_WORDS(2048)) dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(bus), .o_bus_ack(ack),
    .o_bus_rdata(rdata), .i_base_strap(base), .i_laser_idle_strap(idle),
    .o_sdec_wr(sdw), .o_sdec_rd(sdr), .o_sgen_wr(sgw), .o_ext_index(),
    .o_ext_wdata(),
    .i_sdec_rdata(sdec), .o_chan_sel(chan), .o_laser(laser),
    .o_vert_clamp(clamp), .o_vertical_line_interrupt(irq), .i_link_clk(lclk),
    .i_hsync_det(hs), .i_vsync_det(vs), .i_line_end(le),
    .i_second_field(sf), .i_hroi(hroi), .i_adc_sample(smp), .i_adc_ovf(ovf),
    .o_pclk(pclk), .o_line_start_strobe_n(line_n),
    .o_frame_start_strobe_n(frame_n), .o_region_flag_n(roi_n),
    .o_field_parity_line(field), .o_pix_data(pix), .o_acq_oe(oe));

  // ****************
  // helpers
  // ****************
  task automatic chk(input string what, input logic [15:0] e,
    input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [7:0] ad(input logic [3:0] o);
    return {base, o};
  endfunction

  // note bit 8 marks a read whose data must be compared
  task automatic rw(input logic wr, input logic [7:0] a, input logic [7:0] d,
    input logic [8:0] e, input int ws);
    logic [7:0] r;
    int w;
    @(posedge i_clk);
    #1;
    if (ws >= 0) exp_q.push_back(e);
    master_u.access(wr, a, d, r, w);
    chk("wait states", 16'(ws), 16'(w));
  endtask

  always @(posedge i_clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected ack", 16'h0000, 16'h0001);
      end else begin
        note = exp_q.pop_front();
        if (note[8]) chk("read data", 16'(note[7:0]), 16'(rdata));
      end
    end
  end

  // strobes towards the decoder and generator register ports
  always @(posedge i_clk) begin
    if (sdw === 1'b1 || sgw === 1'b1) ext_wr++;
    if (sdr === 1'b1) ext_rd++;
  end

  task automatic lcyc();
    @(posedge lclk);
    #1;
  endtask

  // one video line, with a vertical sync ahead of it when v is set
  task automatic line(input logic v, input logic f);
    logic [15:0] pe;
    logic lx;
    lcyc();
    vs = v;
    sf = f;
    lcyc();
    vs = 1'b0;
    hs = 1'b1;
    lcyc();
    hs = 1'b0;
    idx = v ? 11'h000 : idx + 11'h001;
    // buffered modes keep the channel written before the last frame strobe
    if (v) bch = pend;
    che = (mode == SEL_LUT) ? tbl[idx][7:6] : bch;
    if (v) fe = f;
    chk("line strobe", 16'h0000, 16'(line_n));
    chk("frame strobe", 16'(!v), 16'(frame_n));
    chk("field", 16'(fe), 16'(field));
    for (int k = 0; k < 6; k++) begin
      {smp, ovf} = (k == 0) ? 13'h0FFF : (k == 1) ? 13'h1000 : 13'($urandom);
      pe = {smp, 3'b000, ovf};
      lcyc();
      if (k == 0) chk("line strobe", 16'h0001, 16'(line_n));
      chk("pixel word", pe, 16'(pix));
      pe = k ? 16'h8000 : 16'h7FF1;
      if (k < 2) chk("pixel limit", pe, 16'(pix));
      if (k == 2) begin
        #20;
        chk("pixel clock run", 16'h0001, 16'(pclk));
      end
    end
    le = 1'b1;
    lcyc();
    le = 1'b0;
    repeat (3) lcyc();
    #20;
    chk("pixel clock stop", 16'h0000, 16'(pclk));
    chk("frame strobe", 16'(!v), 16'(frame_n));
    chk("channel", 16'(che), 16'(chan));
    chk("clamp", 16'(tbl[idx][5]), 16'(clamp));
    chk("region", 16'(!tbl[idx][4]), 16'(roi_n));
    lx = (mode == SEL_BUF_IRQ) && tbl[idx][6];
    chk("interrupt", 16'(lx), 16'(irq));
    for (int j = 0; j < 4; j++) begin
      lx = (j == che && tbl[idx][j]) ? ~idle : idle;
      chk("laser", 16'(lx), 16'(laser[j]));
    end
  endtask

  initial begin
    #3_000_000;
    fail_count++;
    report_and_stop();
  end

  // ****************
  // tests
  // ****************
  initial begin
    void'($urandom(32'hc136));
    base = 4'($urandom);
    idle = 1'($urandom);
    repeat (16) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    chk("laser idle", 16'({4{idle}}), 16'(laser));
    chk("bus drivers", 16'h0000, 16'(oe));
    rw(1'b0, ad(OFS_STATUS), 8'h00, 9'h103, 1);
    $display("test reset done");
    for (int o = 0; o < 16; o++) begin
      sdec = 8'($urandom);
      wd = (o == 0) ? CTRL_RST : 8'($urandom);
      rw(1'b1, ad(4'(o)), wd, 9'h000,
        (o == 8) ? 2 : (o == 1) ? 1 : 0);
      e9 = (o == 1) ? 9'h103 : (o < 4) ? {1'b1, sdec} : 9'h100;
      if (o inside {[1:3], [9:15]}) begin
        rw(1'b0, ad(4'(o)), 8'h00, e9, (o < 4) ? 1 : 0);
      end
    end
    rw(1'b1, {~base, 4'h0}, 8'hC0, 9'h000, -1);
    rw(1'b0, ad(OFS_STATUS), 8'h00, 9'h103, 1);
    chk("port writes", 16'h0006, 16'(ext_wr));
    chk("decoder reads", 16'h0002, 16'(ext_rd));
    $display("test window done");
    for (int c = 0; c < 4; c++) begin
      rw(1'b1, ad(OFS_CTRL), 8'hC4 | 8'(c), 9'h000, 0);
      chk("channel", 16'(c), 16'(chan));
      chk("laser off", 16'({4{idle}}), 16'(laser));
      rw(1'b0, ad(OFS_STATUS), 8'h00, {7'h40, 2'(c)}, 1);
    end
    chk("bus drivers", 16'h0001, 16'(oe));
    $display("test direct done");
    rw(1'b1, ad(OFS_CTRL), 8'hF4, 9'h000, 0);
    rw(1'b1, ad(OFS_CTRL), 8'hD4, 9'h000, 0);
    for (int i = 0; i < 2048; i++) begin
      tbl[i] = 8'($urandom);
      rw(1'b1, ad(OFS_LUT_DATA), tbl[i], 9'h000, 2);
    end
    for (int i = 0; i < 4; i++) begin
      rw(1'b0, ad(OFS_LUT_DATA), 8'h00, {1'b1, tbl[i]}, 2);
    end
    rw(1'b1, ad(OFS_CTRL), 8'hF4, 9'h000, 0);
    repeat (2) rw(1'b0, ad(OFS_LUT_DATA), 8'h00, {1'b1, tbl[0]}, 2);
    $display("test table done");
    rw(1'b1, ad(OFS_CTRL), 8'h00, 9'h000, 0);
    mode = SEL_LUT;
    line(1'b1, 1'b0);
    line(1'b0, 1'b0);
    pend = 2'h2;
    rw(1'b1, ad(OFS_CTRL), 8'h82, 9'h000, 0);
    mode = SEL_BUF_IRQ;
    line(1'b0, 1'b0);
    line(1'b1, 1'b1);
    pend = 2'h1;
    rw(1'b1, ad(OFS_CTRL), 8'h41, 9'h000, 0);
    mode = SEL_BUF;
    line(1'b0, 1'b1);
    line(1'b1, 1'b0);
    rw(1'b0, ad(OFS_STATUS), 8'h00, 9'h101, 1);
    $display("test frames done");
    report_and_stop();
  end
endmodule
